// ---- shared/adc_ctrl_pkg.sv ----
// Constants, field positions and state codes shared by the converter control.
// Assumes a single 50 MHz system clock.
package adc_ctrl_pkg;

  localparam int CLOCK_PERIOD_NS = 20;
  localparam int RESULT_WIDTH = 10;
  localparam int CHANNEL_COUNT = 4;
  localparam int STEP_WIDTH = 8;

  // Comparator settling time before a start is trusted, in ns.
  localparam int COMP_SETTLE_NS = 1000;
  localparam int COMP_SETTLE_CYCLES =
    (COMP_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SETTLE_WIDTH = 7;

  // Setup interval between the run bit and the first bit trial.
  localparam int SAMPLE_CYCLES = 16;

  // Mode register fields.
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_FR_MSB = 5;
  localparam int MODE_FR_LSB = 3;
  localparam int MODE_CMP_EN_BIT = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'hb9;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CHAN_WRITE_MASK = 8'h03;
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [CHANNEL_COUNT-1:0] PIN_SEL_RESET = 4'hf;
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 10'h000;
  localparam logic [RESULT_WIDTH-1:0] SAR_FIRST_CODE = 10'h200;

  typedef enum logic [2:0] {
    SAR_IDLE = 3'b001,
    SAR_SAMPLE = 3'b010,
    SAR_TRIAL = 3'b100
  } sar_state_t;

  // Clocks per bit trial for each conversion time selection.
  function automatic logic [STEP_WIDTH-1:0] step_cycles(input logic [2:0] sel);
    logic [STEP_WIDTH-1:0] cycles;
    case (sel)
      3'h0: cycles = 8'h40;
      3'h1: cycles = 8'h30;
      3'h2: cycles = 8'h20;
      3'h3: cycles = 8'h18;
      3'h4: cycles = 8'h10;
      3'h5: cycles = 8'h0c;
      3'h6: cycles = 8'h08;
      default: cycles = 8'h06;
    endcase
    return cycles;
  endfunction : step_cycles

endpackage : adc_ctrl_pkg

// ---- shared/sar_if.sv ----
// Link between the sequencing logic and the bit-trial engine.
// Assumes both ends share one clock.
interface sar_if;
  import adc_ctrl_pkg::*;
  logic start;
  logic abort;
  logic [STEP_WIDTH-1:0] step;
  logic cmp;
  logic busy;
  logic done;
  logic sampling;
  logic [RESULT_WIDTH-1:0] result;
  logic [RESULT_WIDTH-1:0] dac_code;

  modport ctrl (output start, abort, step, cmp, input busy, done, sampling, result, dac_code);
  modport engine (input start, abort, step, cmp, output busy, done, sampling, result, dac_code);
endinterface : sar_if

// ---- rtl/sar_engine.sv ----
// Successive-approximation bit-trial engine.
// Assumes a synchronised comparator level and a start request held while wanted.
module sar_engine
  import adc_ctrl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  sar_if.engine bus
);

  sar_state_t state;
  sar_state_t next_state;
  logic [STEP_WIDTH-1:0] count;
  logic [STEP_WIDTH-1:0] next_count;
  logic [RESULT_WIDTH-1:0] code;
  logic [RESULT_WIDTH-1:0] next_code;
  logic [RESULT_WIDTH-1:0] probe;
  logic [RESULT_WIDTH-1:0] next_probe;
  logic done;
  logic next_done;

  // ****************************************************************
  // Trial sequencing
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_code = code;
    next_probe = probe;
    next_done = 1'b0;
    case (state)
      SAR_IDLE:
      begin
        if (bus.start && !bus.abort)
        begin
          next_state = SAR_SAMPLE;
          next_count = STEP_WIDTH'(SAMPLE_CYCLES - 1);
        end
      end
      SAR_SAMPLE:
      begin
        if (bus.abort)
          next_state = SAR_IDLE;
        else if (count == '0)
        begin
          // The selected time governs only the bit trials that follow.
          next_state = SAR_TRIAL;
          next_count = bus.step - 1'b1;
          next_code = SAR_FIRST_CODE;
          next_probe = SAR_FIRST_CODE;
        end
        else
          next_count = count - 1'b1;
      end
      SAR_TRIAL:
      begin
        if (bus.abort)
          next_state = SAR_IDLE;
        else if (count == '0)
        begin
          next_code = (bus.cmp ? code : (code & ~probe)) | (probe >> 1);
          next_probe = probe >> 1;
          next_count = bus.step - 1'b1;
          if (probe[0])
          begin
            next_state = SAR_IDLE;
            next_done = 1'b1;
          end
        end
        else
          next_count = count - 1'b1;
      end
      default: next_state = SAR_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= SAR_IDLE;
      count <= '0;
      code <= RESULT_RESET;
      probe <= RESULT_RESET;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      code <= next_code;
      probe <= next_probe;
      done <= next_done;
    end
  end

  assign bus.busy = (state != SAR_IDLE);
  assign bus.sampling = (state == SAR_SAMPLE);
  assign bus.done = done;
  assign bus.result = code;
  assign bus.dac_code = code;

endmodule : sar_engine

// ---- rtl/adc_sequencer.sv ----
// Control side of a 10-bit successive-approximation converter.
// Assumes register strobes come from the CPU on i_clock; pins are asynchronous.
module adc_sequencer
  import adc_ctrl_pkg::*;
#(
  parameter int CHANNELS = CHANNEL_COUNT
)
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_mode_wr,
  input wire logic [7:0] i_mode_wdata,
  input wire logic i_chan_wr,
  input wire logic [7:0] i_chan_wdata,
  input wire logic i_pin_sel_wr,
  input wire logic [CHANNELS-1:0] i_pin_sel_wdata,
  input wire logic i_result_rd,
  input wire logic i_stop_mode,
  input wire logic i_comparator,
  input wire logic [CHANNELS-1:0] i_pin_in,
  input wire logic [CHANNELS-1:0] i_port_out,
  input wire logic [CHANNELS-1:0] i_port_oe,
  output logic [7:0] o_converter_mode_reg,
  output logic [7:0] o_channel_select_reg,
  output logic [CHANNELS-1:0] o_analog_pin_select_reg,
  output logic [RESULT_WIDTH-1:0] o_result_word_reg,
  output logic [7:0] o_result_upper_byte_reg,
  output logic o_conversion_done_irq,
  output logic o_result_suspect,
  output logic o_busy,
  output logic o_sample,
  output logic [RESULT_WIDTH-1:0] o_dac_code,
  output logic [CHANNELS-1:0] o_digital_in,
  output logic [CHANNELS-1:0] o_pin_out,
  output logic [CHANNELS-1:0] o_pin_oe
);

  sar_if sar ();

  logic [7:0] mode;
  logic [7:0] next_mode;
  logic [7:0] chan;
  logic [7:0] next_chan;
  logic [CHANNELS-1:0] pin_sel;
  logic [CHANNELS-1:0] next_pin_sel;
  logic [RESULT_WIDTH-1:0] result;
  logic [RESULT_WIDTH-1:0] next_result;
  logic [RESULT_WIDTH-1:0] held;
  logic [RESULT_WIDTH-1:0] next_held;
  logic held_valid;
  logic next_held_valid;
  logic irq;
  logic next_irq;
  logic [SETTLE_WIDTH-1:0] settle;
  logic [SETTLE_WIDTH-1:0] next_settle;
  logic run_prev;
  logic first_bad;
  logic next_first_bad;
  logic suspect;
  logic next_suspect;
  logic cmp_meta;
  logic cmp_sync;
  logic [CHANNELS-1:0] pin_meta;
  logic [CHANNELS-1:0] pin_sync;
  logic [CHANNELS-1:0] digital_in;
  logic [CHANNELS-1:0] pin_out;
  logic [CHANNELS-1:0] pin_oe;
  logic busy;
  logic sample;
  logic [RESULT_WIDTH-1:0] dac_code;

  logic run;
  logic cfg_write;
  logic accept;

  // ****************************************************************
  // Synchronisers for pin and comparator levels
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      cmp_meta <= i_comparator;
      cmp_sync <= cmp_meta;
      pin_meta <= i_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ****************************************************************
  // Run control and engine hookup
  // ****************************************************************
  assign run = mode[MODE_RUN_BIT] && !i_stop_mode;
  assign cfg_write = i_mode_wr || i_chan_wr;
  assign accept = sar.done && !cfg_write;

  assign sar.start = run;
  // A configuration write restarts the conversion; the old trial is dropped.
  assign sar.abort = !run || cfg_write;
  assign sar.step = step_cycles(mode[MODE_FR_MSB:MODE_FR_LSB]);
  assign sar.cmp = cmp_sync;

  sar_engine u_engine (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .bus(sar.engine)
  );

  // ****************************************************************
  // Registers, result loading and start qualification
  // ****************************************************************
  always_comb
  begin
    next_mode = mode;
    next_chan = chan;
    next_pin_sel = pin_sel;
    next_result = result;
    next_held = held;
    next_held_valid = held_valid;
    next_irq = 1'b0;
    next_settle = settle;
    next_first_bad = first_bad;
    next_suspect = suspect;

    if (i_mode_wr)
      next_mode = i_mode_wdata & MODE_WRITE_MASK;
    if (i_chan_wr)
      next_chan = i_chan_wdata & CHAN_WRITE_MASK;
    if (i_pin_sel_wr)
      next_pin_sel = i_pin_sel_wdata;

    // Settling time counted from comparator enable.
    if (!mode[MODE_CMP_EN_BIT])
      next_settle = '0;
    else if (settle < SETTLE_WIDTH'(COMP_SETTLE_CYCLES))
      next_settle = settle + 1'b1;

    // A fresh start too early or with the comparator off marks the first result.
    if (run && !run_prev)
      next_first_bad = !mode[MODE_CMP_EN_BIT]
        || (settle < SETTLE_WIDTH'(COMP_SETTLE_CYCLES));

    if (held_valid && !i_result_rd)
    begin
      next_result = held;
      next_held_valid = 1'b0;
    end

    if (accept)
    begin
      next_irq = 1'b1;
      next_first_bad = 1'b0;
      if (i_result_rd)
      begin
        next_held = sar.result;
        next_held_valid = 1'b1;
      end
      else
      begin
        next_result = sar.result;
        next_held_valid = 1'b0;
      end
      next_suspect = first_bad;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mode <= MODE_RESET;
      chan <= CHAN_RESET;
      pin_sel <= PIN_SEL_RESET;
      result <= RESULT_RESET;
      held <= RESULT_RESET;
      held_valid <= 1'b0;
      irq <= 1'b0;
      settle <= '0;
      run_prev <= 1'b0;
      first_bad <= 1'b0;
      suspect <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      chan <= next_chan;
      pin_sel <= next_pin_sel;
      result <= next_result;
      held <= next_held;
      held_valid <= next_held_valid;
      irq <= next_irq;
      settle <= next_settle;
      run_prev <= run;
      first_bad <= next_first_bad;
      suspect <= next_suspect;
    end
  end

  // ****************************************************************
  // Pin routing and registered engine view
  // ****************************************************************
  always_comb
  begin
    digital_in = pin_sync & ~pin_sel;
    pin_out = i_port_out & ~pin_sel;
    pin_oe = i_port_oe & ~pin_sel;
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_digital_in <= '0;
      o_pin_out <= '0;
      o_pin_oe <= '0;
      busy <= 1'b0;
      sample <= 1'b0;
      dac_code <= RESULT_RESET;
    end
    else
    begin
      o_digital_in <= digital_in;
      o_pin_out <= pin_out;
      o_pin_oe <= pin_oe;
      busy <= sar.busy;
      sample <= sar.sampling;
      dac_code <= sar.dac_code;
    end
  end

  assign o_converter_mode_reg = mode;
  assign o_channel_select_reg = chan;
  assign o_analog_pin_select_reg = pin_sel;
  assign o_result_word_reg = result;
  assign o_result_upper_byte_reg = result[RESULT_WIDTH-1:RESULT_WIDTH-8];
  assign o_conversion_done_irq = irq;
  assign o_result_suspect = suspect;
  assign o_busy = busy;
  assign o_sample = sample;
  assign o_dac_code = dac_code;

endmodule : adc_sequencer

// ---- tb/adc_seq_chk.sv ----
// Port checker for the converter control block.
// Assumes it is bound to every adc_sequencer instance.
module adc_seq_chk
  import adc_ctrl_pkg::*;
#(
  parameter int CHANNELS = CHANNEL_COUNT
)
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_mode_wr,
  input wire logic [7:0] i_mode_wdata,
  input wire logic i_chan_wr,
  input wire logic i_result_rd,
  input wire logic i_stop_mode,
  input wire logic [CHANNELS-1:0] i_port_oe,
  input wire logic [7:0] o_converter_mode_reg,
  input wire logic [CHANNELS-1:0] o_analog_pin_select_reg,
  input wire logic [RESULT_WIDTH-1:0] o_result_word_reg,
  input wire logic [7:0] o_result_upper_byte_reg,
  input wire logic o_conversion_done_irq,
  input wire logic o_busy,
  input wire logic [CHANNELS-1:0] o_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  chk_upper_pair: assert property (o_result_upper_byte_reg == o_result_word_reg[9:2])
    else $error("upper byte differs from result");
  chk_irq_pulse: assert property (o_conversion_done_irq |=> !o_conversion_done_irq)
    else $error("done pulse too long");
  chk_read_wins: assert property (i_result_rd |=> $stable(o_result_word_reg))
    else $error("result changed during a read");
  chk_mode_mask: assert property (i_mode_wr |=>
    o_converter_mode_reg == ($past(i_mode_wdata) & MODE_WRITE_MASK))
    else $error("mode register holds wrong value");
  chk_pin_cut: assert property (o_pin_oe == ($past(i_port_oe) & ~$past(o_analog_pin_select_reg)))
    else $error("port drive reaches an analog pin");
  chk_stop_halt: assert property (i_stop_mode [*3] |-> !o_busy)
    else $error("converter busy in stop mode");
  chk_write_wins: assert property ((i_mode_wr || i_chan_wr) |=> !o_conversion_done_irq)
    else $error("done pulse after a colliding write");
  chk_idle_quiet: assert property (!o_converter_mode_reg[7] [*3] |-> !o_conversion_done_irq)
    else $error("done pulse with run bit clear");
  cov_irq: cover property (o_conversion_done_irq);
  cov_read_clash: cover property (i_result_rd ##1 o_conversion_done_irq);
  cov_write_busy: cover property (i_chan_wr && o_busy);
endmodule : adc_seq_chk

bind adc_sequencer adc_seq_chk #(.CHANNELS(CHANNELS)) u_adc_seq_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_mode_wr(i_mode_wr),
  .i_mode_wdata(i_mode_wdata), .i_chan_wr(i_chan_wr), .i_result_rd(i_result_rd),
  .i_stop_mode(i_stop_mode), .i_port_oe(i_port_oe),
  .o_converter_mode_reg(o_converter_mode_reg),
  .o_analog_pin_select_reg(o_analog_pin_select_reg),
  .o_result_word_reg(o_result_word_reg), .o_result_upper_byte_reg(o_result_upper_byte_reg),
  .o_conversion_done_irq(o_conversion_done_irq), .o_busy(o_busy), .o_pin_oe(o_pin_oe));

// ---- tb/tb_top.sv ----
// Self-checking bench for the converter control block.
// Assumes the checker file binds itself into the design.
module tb_top
  import adc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int k; logic [7:0] d; logic [7:0] e;} row_t;
  row_t rows[8] = '{'{0, 8'h7f, 8'h39}, '{0, 8'h46, 8'h00}, '{1, 8'hff, 8'h03},
    '{1, 8'h06, 8'h02}, '{2, 8'h05, 8'h05}, '{2, 8'h0a, 8'h0a}, '{2, 8'h00, 8'h00},
    '{2, 8'h0f, 8'h0f}};
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic mwr = 1'b0;
  logic cwr = 1'b0;
  logic pwr = 1'b0;
  logic rd = 1'b0;
  logic stop = 1'b0;
  logic comp = 1'b1;
  logic [7:0] wd = 8'h00;
  logic [7:0] mode, chan, upper;
  logic [3:0] psel, din, pout, poe;
  logic [9:0] res, dac;
  logic irq, susp, busy, samp;
  int num_errors = 0;
  int checked = 0;
  int n, p, hits;

  always #10 i_clock = ~i_clock;

  adc_sequencer u_adc_sequencer (.i_clock(i_clock), .i_resetn(i_resetn), .i_mode_wr(mwr),
    .i_mode_wdata(wd), .i_chan_wr(cwr), .i_chan_wdata(wd), .i_pin_sel_wr(pwr),
    .i_pin_sel_wdata(wd[3:0]), .i_result_rd(rd), .i_stop_mode(stop), .i_comparator(comp),
    .i_pin_in(4'hc), .i_port_out(4'ha), .i_port_oe(4'hf), .o_converter_mode_reg(mode),
    .o_channel_select_reg(chan), .o_analog_pin_select_reg(psel), .o_result_word_reg(res),
    .o_result_upper_byte_reg(upper), .o_conversion_done_irq(irq), .o_result_suspect(susp),
    .o_busy(busy), .o_sample(samp), .o_dac_code(dac), .o_digital_in(din), .o_pin_out(pout),
    .o_pin_oe(poe));

  // ****************
  // Tasks
  // ****************
  task automatic tick(input int c = 1);
    repeat (c) @(posedge i_clock);
    #2;
  endtask : tick

  task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : cmp

  task automatic wr(input int k, input logic [7:0] d);
    mwr = (k == 0);
    cwr = (k == 1);
    pwr = (k == 2);
    wd = d;
    tick();
    mwr = 1'b0;
    cwr = 1'b0;
    pwr = 1'b0;
  endtask : wr

  task automatic wait_irq(output int c);
    c = 0;
    do
    begin
      tick();
      c++;
    end
    while (irq !== 1'b1 && c < 2000);
    if (irq !== 1'b1)
    begin
      num_errors++;
      $display("unexpected irq expected pulse seen none");
    end
  endtask : wait_irq

  task automatic quiet(input int c);
    hits = 0;
    repeat (c)
    begin
      if (irq !== 1'b0)
        hits++;
      tick();
    end
  endtask : quiet

  task automatic complete_run();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // ****************
  // Tests
  // ****************
  initial
  begin
    #100us;
    num_errors++;
    $display("unexpected watchdog expected end seen timeout");
    complete_run();
  end

  initial
  begin
    tick(12);
    i_resetn = 1'b1;
    cmp("reset", 16'h00f8, {mode, psel, res == 10'h000, irq, susp, busy});
    cmp("reset pins", 10'h000, {chan, poe});
    foreach (rows[i])
    begin
      wr(rows[i].k, rows[i].d);
      tick(3);
      cmp("register", rows[i].e, rows[i].k == 0 ? mode : rows[i].k == 1 ? chan : psel);
      if (rows[i].k == 2)
        cmp("pin gating", {~rows[i].e[3:0], 4'ha & ~rows[i].e[3:0], 2'b00},
          {poe, pout, 2'b00});
      if (rows[i].k == 2)
        cmp("digital in", 4'hc & ~rows[i].e[3:0], din);
    end
    $display("test registers done");
    wr(0, 8'hb8);
    wait_irq(n);
    cmp("span fast", 1, n >= 76 && n <= 84);
    cmp("result", {10'h3ff}, res);
    cmp("upper", 8'hff, upper);
    cmp("trial code", 10'h3ff, dac);
    cmp("suspect", 1, susp);
    wait_irq(p);
    cmp("period", 1, p >= 76 && p <= 84);
    cmp("suspect later", 0, susp);
    $display("test conversion done");
    comp = 1'b0;
    tick(p - 1);
    wr(1, 8'h01);
    quiet(20);
    cmp("clash irq", 0, hits);
    cmp("clash result", 10'h3ff, res);
    wait_irq(n);
    cmp("restart result", 10'h000, res);
    $display("test write clash done");
    comp = 1'b1;
    rd = 1'b1;
    wait_irq(n);
    cmp("read old", 10'h000, res);
    rd = 1'b0;
    tick();
    cmp("read new", 10'h3ff, res);
    $display("test read clash done");
    stop = 1'b1;
    quiet(200);
    cmp("stop irq", 0, hits);
    cmp("stop busy", 0, busy);
    stop = 1'b0;
    tick(3);
    cmp("resume sample", 2'b11, {samp, busy});
    wait_irq(n);
    cmp("resume", 1, n < 2000);
    cmp("resume result", 10'h3ff, res);
    wr(0, 8'h00);
    tick(3);
    cmp("run off busy", 0, busy);
    stop = 1'b1;
    quiet(5);
    stop = 1'b0;
    cmp("stop idle", 0, hits);
    $display("test stop done");
    wr(1, 8'h00);
    tick();
    wr(0, 8'h01);
    tick(60);
    wr(0, 8'h81);
    wait_irq(n);
    cmp("span slow", 1, n >= 656 && n <= 664);
    cmp("settled suspect", 0, susp);
    tick(30);
    i_resetn = 1'b0;
    tick(2);
    i_resetn = 1'b1;
    cmp("mid reset", 16'h0004, {mode, res == 10'h000, busy, irq});
    $display("test reset done");
    complete_run();
  end
endmodule : tb_top
